/* File: shp_serial_port.v */
`timescale 1ns/10ps
`default_nettype none
`include "shp_consts.vh"

module shp_serial_port
(
   // clock and reset
   input  wire       clk_sys_i,
   input  wire       reset_n_i,
   // host interface selection straps
   input  wire       strap_wr_i,
   input  wire       strap_rd_i,
   input  wire       strap_ale_i,
   // serial control port
   input  wire       cs_n_i,
   input  wire       sck_i,
   input  wire       serial_rx_line_i,
   output wire       serial_tx_line_o,
   output wire       serial_tx_line_oe_o,
   // register side
   output wire [7:0] reg_addr_o,
   output wire [7:0] reg_wdata_o,
   output wire       reg_wr_o,
   output wire       reg_rd_o,
   input  wire [7:0] reg_rdata_i,
   output wire [5:0] buf_ptr_o,
   output wire       buf_access_o,
   // selected host interface
   output wire       serial_sel_o,
   output wire       parallel_sel_o,
   output wire       monitor_sel_o,
   // interrupt
   input  wire       irq_event_i,
   input  wire       irq_pol_high_i,
   output wire       irq_o
);

   localparam [7:0] ST_IDLE   = 8'h01;
   localparam [7:0] ST_HDR    = 8'h02;
   localparam [7:0] ST_ADDR   = 8'h04;
   localparam [7:0] ST_WDATA  = 8'h08;
   localparam [7:0] ST_RSLOT  = 8'h10;
   localparam [7:0] ST_CONST  = 8'h20;
   localparam [7:0] ST_WBURST = 8'h40;
   localparam [7:0] ST_DEAD   = 8'h80;

   // straps run unreset so they can be caught while reset is held
   reg  [1:0] strap_cs_ff;
   reg  [2:0] strap_a_ff;
   reg  [2:0] strap_b_ff;
   reg        rst_s1_ff;
   reg        rst_s2_ff;
   reg        serial_mode_ff;
   reg        parallel_mode_ff;
   reg        monitor_mode_ff;

   reg  [2:0] sck_sync_ff;
   reg  [2:0] cs_sync_ff;
   reg  [1:0] rx_sync_ff;

   reg  [7:0] state_ff;
   reg  [7:0] nxt_state;
   reg  [2:0] bit_cnt_ff;
   reg  [7:0] rx_sh_ff;
   reg        half_ff;
   reg        interleave_ff;
   reg        const_rd_ff;
   reg        fmt_const_ff;
   reg        fmt_rw_ff;
   reg  [7:0] addr_ff;
   reg  [7:0] wdata_ff;
   reg        wr_ff;
   reg        rd_ff;
   reg        rd_cap_ff;
   reg  [7:0] rd_buf_ff;
   reg        pend_ff;
   reg  [7:0] tx_sh_ff;
   reg        tx_en_ff;
   reg  [5:0] ptr_ff;
   reg        pol_ff;
   reg        ev_ff;
   reg        irq_ff;

   wire       sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
   wire       sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
   wire       cs_act   = ~cs_sync_ff[1] & serial_mode_ff;
   wire       cs_fall  = cs_sync_ff[2] & ~cs_sync_ff[1];
   wire       byte_done = cs_act & sck_rise & (bit_cnt_ff == `SHP_BIT_LAST);
   wire [7:0] rx_byte  = {rx_sh_ff[6:0], rx_sync_ff[1]};
   wire [7:0] hdr_code = rx_byte & `SHP_HDR_HALF_MASK;
   wire       adr_rd   = rx_byte[`SHP_ADR_RD_BIT];
   wire [7:0] full_adr = {half_ff, rx_byte[`SHP_ADR_IDX_W-1:0]};
   wire       is_buf   = ((addr_ff >= `SHP_BUF_LO) && (addr_ff <= `SHP_BUF_HI))
                         || (addr_ff == `SHP_BUF_ALT0)
                         || (addr_ff == `SHP_BUF_ALT1);

   always @(posedge clk_sys_i)
   begin
      strap_a_ff  <= {strap_wr_i, strap_rd_i, strap_ale_i};
      strap_b_ff  <= strap_a_ff;
      strap_cs_ff <= {strap_cs_ff[0], cs_n_i};
   end

   always @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         {rst_s2_ff, rst_s1_ff} <= 2'h0;
      else
         {rst_s2_ff, rst_s1_ff} <= {rst_s1_ff, 1'b1};
   end

   // cs doubles as a strap; the last value seen under reset sticks
   always @(posedge clk_sys_i)
   begin
      if (!rst_s2_ff)
      begin
         serial_mode_ff   <= ~strap_b_ff[2] & ~strap_b_ff[1] &
                             strap_cs_ff[1] & ~strap_b_ff[0];
         monitor_mode_ff  <= ~strap_b_ff[2] & ~strap_b_ff[1] &
                             ~strap_cs_ff[1] & ~strap_b_ff[0];
         parallel_mode_ff <= strap_b_ff[2] & strap_b_ff[1];
      end
   end

   always @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sck_sync_ff <= 3'h0;
         cs_sync_ff  <= 3'h7;
         rx_sync_ff  <= 2'h0;
      end
      else
      begin
         sck_sync_ff <= {sck_sync_ff[1:0], sck_i};
         cs_sync_ff  <= {cs_sync_ff[1:0], cs_n_i};
         rx_sync_ff  <= {rx_sync_ff[0], serial_rx_line_i};
      end
   end

   always @*
   begin
      nxt_state = state_ff;
      if (!cs_act)
         nxt_state = ST_IDLE;
      else if (cs_fall)
         nxt_state = ST_HDR;
      else if (byte_done)
      begin
         case (state_ff)
            ST_HDR:
               if ((hdr_code == `SHP_HDR_ALT_NI) ||
                   (hdr_code == `SHP_HDR_ALT_IL) ||
                   (hdr_code == `SHP_HDR_CONST)  ||
                   (hdr_code == `SHP_HDR_RW_NI)  ||
                   (hdr_code == `SHP_HDR_RW_IL))
                  nxt_state = ST_ADDR;
               else
                  nxt_state = ST_DEAD;
            ST_ADDR:
               if (fmt_const_ff)
                  nxt_state = ST_CONST;
               else if (adr_rd)
                  nxt_state = interleave_ff ? ST_ADDR : ST_RSLOT;
               else if (fmt_rw_ff)
                  nxt_state = ST_WBURST;
               else
                  nxt_state = ST_WDATA;
            ST_WDATA:  nxt_state = ST_ADDR;
            ST_RSLOT:  nxt_state = ST_ADDR;
            ST_CONST, ST_WBURST, ST_DEAD: nxt_state = state_ff;
            default:   nxt_state = ST_IDLE;
         endcase
      end
   end

   always @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_ff      <= ST_IDLE;
         bit_cnt_ff    <= 3'h0;
         rx_sh_ff      <= 8'h00;
         half_ff       <= 1'b0;
         interleave_ff <= 1'b0;
         fmt_const_ff  <= 1'b0;
         fmt_rw_ff     <= 1'b0;
         const_rd_ff   <= 1'b0;
         addr_ff       <= 8'h00;
         wdata_ff      <= 8'h00;
         wr_ff         <= 1'b0;
         rd_ff         <= 1'b0;
         ptr_ff        <= `SHP_PTR_RST;
      end
      else
      begin
         state_ff <= nxt_state;
         wr_ff    <= 1'b0;
         rd_ff    <= 1'b0;
         if (!cs_act || cs_fall)
            bit_cnt_ff <= 3'h0; // partial bytes dropped
         else if (sck_rise)
         begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            rx_sh_ff   <= rx_byte; // msb first
         end
         // pointer moves on only after an access has used it
         if ((wr_ff || rd_ff) && fmt_const_ff && is_buf)
            ptr_ff <= ptr_ff + 6'h01;
         if (byte_done)
         begin
            case (state_ff)
               ST_HDR:
               begin
                  half_ff       <= rx_byte[`SHP_HDR_HALF_BIT];
                  interleave_ff <= rx_byte[3];
                  fmt_const_ff  <= (hdr_code == `SHP_HDR_CONST);
                  fmt_rw_ff     <= rx_byte[0] & ~rx_byte[1];
                  const_rd_ff   <= 1'b0;
                  ptr_ff        <= `SHP_PTR_RST;
               end
               ST_ADDR:
               begin
                  addr_ff     <= full_adr;
                  rd_ff       <= adr_rd;
                  const_rd_ff <= adr_rd; // direction of a constant stream
               end
               ST_WDATA, ST_WBURST:
               begin
                  wdata_ff <= rx_byte;
                  wr_ff    <= 1'b1;
               end
               ST_CONST:
               begin
                  wdata_ff <= rx_byte;
                  wr_ff    <= ~const_rd_ff;
                  rd_ff    <= const_rd_ff;
               end
               default: wr_ff <= 1'b0;
            endcase
         end
      end
   end

   // read data held for the next byte boundary on the falling edge
   always @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rd_cap_ff <= 1'b0;
         rd_buf_ff <= 8'h00;
         pend_ff   <= 1'b0;
         tx_sh_ff  <= 8'h00;
         tx_en_ff  <= 1'b0;
      end
      else
      begin
         rd_cap_ff <= rd_ff;
         if (!cs_act)
         begin
            pend_ff  <= 1'b0;
            tx_en_ff <= 1'b0;
         end
         else
         begin
            if (sck_fall && bit_cnt_ff == 3'h0)
            begin
               tx_en_ff <= pend_ff;
               tx_sh_ff <= rd_buf_ff;
               pend_ff  <= 1'b0;
            end
            else if (sck_fall && tx_en_ff)
               tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            // a fresh read outranks the clear at the slot boundary
            if (rd_cap_ff)
            begin
               rd_buf_ff <= reg_rdata_i;
               pend_ff   <= 1'b1;
            end
         end
      end
   end

   // event and polarity share a stage, so a joint change cannot glitch
   always @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         {pol_ff, ev_ff} <= 2'h0;
         irq_ff <= 1'b1;
      end
      else
      begin
         {pol_ff, ev_ff} <= {irq_pol_high_i, irq_event_i};
         irq_ff <= pol_ff ? ev_ff : ~ev_ff;
      end
   end

   assign serial_tx_line_o    = tx_sh_ff[7];
   assign serial_tx_line_oe_o = tx_en_ff;
   assign reg_addr_o          = addr_ff;
   assign reg_wdata_o         = wdata_ff;
   assign reg_wr_o            = wr_ff;
   assign reg_rd_o            = rd_ff;
   assign buf_ptr_o           = ptr_ff;
   assign buf_access_o        = fmt_const_ff & is_buf;
   assign serial_sel_o        = serial_mode_ff;
   assign parallel_sel_o      = parallel_mode_ff;
   assign monitor_sel_o       = monitor_mode_ff;
   assign irq_o               = irq_ff;

endmodule // shp_serial_port
`default_nettype wire

/* File: shp_consts.vh */
`ifndef SHP_CONSTS_VH
`define SHP_CONSTS_VH

// header codes with the half-select bit cleared
`define SHP_HDR_ALT_NI     8'h40
`define SHP_HDR_ALT_IL     8'h48
`define SHP_HDR_CONST      8'h43
`define SHP_HDR_RW_NI      8'h41
`define SHP_HDR_RW_IL      8'h49
`define SHP_HDR_HALF_MASK  8'hfb
`define SHP_HDR_HALF_BIT   2

// address byte layout
`define SHP_ADR_RD_BIT     7
`define SHP_ADR_IDX_W      7

// data-buffer window for the constant-address format
`define SHP_BUF_LO         8'h00
`define SHP_BUF_HI         8'h1f
`define SHP_BUF_ALT0       8'h6a
`define SHP_BUF_ALT1       8'h7a
`define SHP_PTR_W          6
`define SHP_PTR_RST        6'h00

// bits in a byte, last bit index
`define SHP_BIT_LAST       3'h7

`endif

/* File: shp_serial_port_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module shp_serial_port_asserts
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // serial side
   input wire logic cs_n_i,
   input wire logic serial_tx_line_oe_o,
   input wire logic reg_wr_o,
   input wire logic reg_rd_o,
   // mode and interrupt
   input wire logic serial_sel_o,
   input wire logic parallel_sel_o,
   input wire logic monitor_sel_o,
   input wire logic irq_event_i,
   input wire logic irq_pol_high_i,
   input wire logic irq_o
);
   logic [2:0] up_ff;
   logic       rd_seen_ff;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   // edges since reset, so $past never looks back into reset
   always @(posedge clk_sys_i or negedge reset_n_i)
      if (!reset_n_i)
         up_ff <= 3'h0;
      else if (up_ff != 3'h7)
         up_ff <= up_ff + 3'h1;

   always @(posedge clk_sys_i or negedge reset_n_i)
      if (!reset_n_i)
         rd_seen_ff <= 1'b0;
      else if (reg_rd_o | cs_n_i)
         rd_seen_ff <= reg_rd_o;

   property p_oe_idle;
      cs_n_i [*8] |-> !serial_tx_line_oe_o;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("tx driven outside a frame");

   property p_wr_idle;
      cs_n_i [*8] |-> !reg_wr_o;
   endproperty
   a_wr_idle: assert property (p_wr_idle)
      else $error("write outside a frame");

   property p_oe_cause;
      $rose(serial_tx_line_oe_o) |-> rd_seen_ff;
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("tx driven without a read");

   property p_wr_pulse;
      reg_wr_o |=> !reg_wr_o [*4];
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("writes closer than a byte");

   property p_rw_excl;
      !(reg_wr_o && reg_rd_o);
   endproperty
   a_rw_excl: assert property (p_rw_excl)
      else $error("read and write together");

   property p_mode_hold;
      up_ff == 3'h7 |->
         $stable({serial_sel_o, parallel_sel_o, monitor_sel_o});
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("host mode changed after reset");

   property p_mode_one;
      serial_sel_o |-> !parallel_sel_o && !monitor_sel_o;
   endproperty
   a_mode_one: assert property (p_mode_one)
      else $error("two host modes at once");

   property p_irq;
      up_ff == 3'h7 |->
         irq_o == ($past(irq_event_i, 2) == $past(irq_pol_high_i, 2));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt level wrong");
endmodule // shp_serial_port_asserts

bind shp_serial_port shp_serial_port_asserts u_chk
(
   .clk_sys_i, .reset_n_i, .cs_n_i, .serial_tx_line_oe_o, .reg_wr_o,
   .reg_rd_o, .serial_sel_o, .parallel_sel_o, .monitor_sel_o,
   .irq_event_i, .irq_pol_high_i, .irq_o
);
`default_nettype wire

/* File: shp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module shp_host_model
(
   // to device
   output var logic cs_n_o,
   output var logic sck_o,
   output var logic rx_o,
   // from device
   input wire logic tx_i,
   input wire logic tx_oe_i
);
   // shift clock stands low between frames
   initial
   begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      rx_o = 1'b0;
   end

   task start;
      cs_n_o = 1'b0;
      #80;
   endtask

   // released line shows the inverse, never a stale value
   task stop;
      #80;
      cs_n_o = 1'b1;
      rx_o = ~rx_o;
      #400;
   endtask

   task xfer(input logic [7:0] d, input int n, output logic [7:0] q);
      for (int i = 7; i > 7 - n; i--)
      begin
         rx_o = d[i];
         #40 sck_o = 1'b1;
         q[i] = tx_oe_i ? tx_i : ~tx_i;
         #80 sck_o = 1'b0;
         #40;
      end
   endtask
endmodule // shp_host_model
`default_nettype wire

/* File: test_serial_host_register_port.sv */
`timescale 1ns/10ps
`default_nettype none
module test_serial_host_register_port;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        swr = 1'b0;
   logic        srd = 1'b0;
   logic        ev = 1'b0;
   logic        pol = 1'b0;
   logic [7:0]  rdata = 8'h00;
   logic [7:0]  wa;
   logic [7:0]  wd;
   logic [7:0]  ra;
   logic [7:0]  got [0:7];
   logic [31:0] seed = 32'heb29;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          n_wr = 0;
   int          nb;
   int          n;
   wire         cs_n, sck, rx, tx, oe, wr, rd, ser, par, mon, irq, bacc;
   wire  [7:0]  addr;
   wire  [7:0]  wdata;
   wire  [5:0]  ptr;

   initial
      forever #2 clk = ~clk;

   shp_serial_port u_dut
   (
      .clk_sys_i(clk), .reset_n_i(rst_n), .strap_wr_i(swr),
      .strap_rd_i(srd), .strap_ale_i(1'b0), .cs_n_i(cs_n),
      .sck_i(sck), .serial_rx_line_i(rx), .serial_tx_line_o(tx),
      .serial_tx_line_oe_o(oe), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
      .reg_rdata_i(rdata), .buf_ptr_o(ptr), .buf_access_o(bacc),
      .serial_sel_o(ser), .parallel_sel_o(par), .monitor_sel_o(mon),
      .irq_event_i(ev), .irq_pol_high_i(pol), .irq_o(irq)
   );

   shp_host_model u_host
   (
      .cs_n_o(cs_n), .sck_o(sck), .rx_o(rx), .tx_i(tx), .tx_oe_i(oe)
   );

   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      return a ^ 8'h3c;
   endfunction

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   always @(negedge clk)
      rdata <= exp_rd(addr);

   always @(negedge clk)
   begin
      if (wr)
      begin
         n_wr <= n_wr + 1;
         wa <= addr;
         wd <= wdata;
      end
      if (rd)
         ra <= addr;
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task report_and_stop;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task go;
      u_host.start();
      nb = 0;
   endtask

   task b8(input logic [7:0] b);
      u_host.xfer(b, 8, got[nb]);
      nb++;
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end

   initial
   begin
      repeat (20) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(ser, 1'b1);
      swr = 1'b1;
      srd = 1'b1;
      repeat (4) @(negedge clk);
      chk({ser, par, mon}, 3'b100);
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         n = n_wr;
         go();
         b8(i[0] ? 8'h44 : 8'h40);
         b8({1'b0, seed[6:0]});
         b8(seed[15:8]);
         b8({1'b1, seed[6:0]});
         b8(8'h00);
         u_host.stop();
         chk(n_wr - n, 1);
         chk({wa, wd}, {i[0], seed[6:0], seed[15:8]});
         chk(got[4], exp_rd({i[0], seed[6:0]}));
         chk(ra, {i[0], seed[6:0]});
      end
      go();
      b8(8'h48);
      b8(8'h81);
      b8(8'h82);
      b8(8'h00);
      u_host.stop();
      chk(got[2], exp_rd(8'h01));
      chk(got[3], exp_rd(8'h02));
      n = n_wr;
      go();
      b8(8'h40);
      b8(8'h07);
      u_host.xfer(8'hff, 4, got[2]);
      u_host.stop();
      go();
      b8(8'h55);
      b8(8'h03);
      b8(8'h99);
      u_host.stop();
      chk(n_wr - n, 0);
      go();
      b8(8'h43);
      b8(8'h10);
      for (int i = 0; i < 3; i++)
      begin
         seed = xs(seed);
         b8(seed[7:0]);
      end
      chk(bacc, 1'b1);
      chk(ptr, 6'h03);
      u_host.stop();
      chk(n_wr - n, 3);
      n = n_wr;
      go();
      b8(8'h47);
      b8(8'h9a);
      b8(8'h00);
      b8(8'h00);
      u_host.stop();
      chk(got[2], exp_rd(8'h9a));
      chk(got[3], exp_rd(8'h9a));
      chk(ra, 8'h9a);
      chk(n_wr - n, 0);
      for (int k = 0; k < 2; k++)
      begin
         n = n_wr;
         go();
         b8(k ? 8'h49 : 8'h41);
         b8(8'h86);
         if (k == 0)
            b8(8'h00);
         b8(8'h0a);
         b8(8'h5c);
         b8(seed[15:8]);
         u_host.stop();
         chk(got[2], exp_rd(8'h06));
         chk(n_wr - n, 2);
         chk({wa, wd}, {8'h0a, seed[15:8]});
      end
      for (int k = 0; k < 4; k++)
      begin
         @(negedge clk);
         ev = k[0];
         pol = k[1];
         repeat (3) @(negedge clk);
         chk(irq, k[0] == k[1]);
      end
      report_and_stop();
   end
endmodule // test_serial_host_register_port
`default_nettype wire
